/* File: smd_params.svh */
`ifndef SMD_PARAMS_SVH
`define SMD_PARAMS_SVH

// register word indices (printed offsets are all multiples of four: index * 4)
`define SMD_IDX_SHARED_DIR 4'h3
`define SMD_IDX_VSEL_LOW 4'hC
`define SMD_IDX_VSEL_HIGH 4'hD
`define SMD_IDX_MOTOR_CFG 4'h6
`define SMD_IDX_DRIVE 4'h8
`define SMD_IDX_STATUS 4'h9
`define SMD_IDX_STAT_SEL 4'h2

// field positions
`define SMD_DIR_BIT 3
`define SMD_VL_EXT_OFFTRACK 0
`define SMD_VL_KILL_SEL 1
`define SMD_VL_LEVEL 2

// reset values
`define SMD_RST_NIBBLE 4'h0
`define SMD_RST_DRIVE 10'h000

// timing, clock 40 MHz
`define SMD_CLK_HZ 40000000
`define SMD_PDM_HZ 1000000
`define SMD_PWM_HZ 22050
`define SMD_CDV_HZ 300
`define SMD_CDV_PD_HZ 4230000
`define SMD_PDM_DIV (`SMD_CLK_HZ / `SMD_PDM_HZ)
`define SMD_PWM_DIV (`SMD_CLK_HZ / `SMD_PWM_HZ)
`define SMD_CDV_DIV (`SMD_CLK_HZ / `SMD_CDV_HZ)

// elastic buffer spans -8..+8 frames; cdv pwm spans 20 frames, half full gives 60 %
`define SMD_FIFO_SPAN 8
`define SMD_CDV_SPAN 20
`define SMD_CDV_OFFSET 2

`endif

/* File: smd_pkg.sv */
package smd_pkg;

  typedef enum logic [1:0] {
    SMD_MODE_PDM = 2'b00,
    SMD_MODE_PWM2 = 2'b01,
    SMD_MODE_PWM4 = 2'b11,
    SMD_MODE_CDV = 2'b10
  } smd_mode_t;

  typedef struct packed {
    logic ext_off_track;
    logic shared_level;
  } smd_pins_in_t;

  typedef struct packed {
    logic motor_out_first;
    logic motor_out_second;
    logic aux_output_pin_a;
    logic aux_output_pin_b;
    logic shared_out;
    logic shared_oe_n;
  } smd_pins_out_t;

  typedef struct packed {
    logic kill_right_n;
    logic subcode_qw;
    logic deemph_active;
    logic int_off_track;
  } smd_core_t;

endpackage

/* File: smd_pdm.sv */
`timescale 1ns/1ps
`include "smd_params.svh"

module smd_pdm (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic tick,
  input wire logic [9:0] level,
  // stream
  output logic bit_out
);

  typedef struct packed {
    logic [9:0] acc;
    logic out;
  } smd_pdm_state_t;

  smd_pdm_state_t st_reg;
  smd_pdm_state_t st_next;

  // first-order accumulator; carry is the bit stream, mid level gives 50 %
  always_comb begin
    logic [10:0] sum;
    sum = 11'h000;
    st_next = st_reg;
    if (tick) begin
      sum = {1'b0, st_reg.acc} + {1'b0, level};
      st_next.acc = sum[9:0];
      st_next.out = sum[10];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign bit_out = st_reg.out;

endmodule

/* File: smd_pwm.sv */
`timescale 1ns/1ps
`include "smd_params.svh"

module smd_pwm (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic [17:0] period,
  input wire logic [17:0] duty,
  // output
  output logic pwm_out
);

  typedef struct packed {
    logic [17:0] cnt;
    logic out;
  } smd_pwm_state_t;

  smd_pwm_state_t st_reg;
  smd_pwm_state_t st_next;

  always_comb begin
    st_next = st_reg;
    if (st_reg.cnt >= period - 18'h00001) begin
      st_next.cnt = 18'h00000;
    end else begin
      st_next.cnt = st_reg.cnt + 18'h00001;
    end
    st_next.out = (st_next.cnt < duty);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign pwm_out = st_reg.out;

endmodule

/* File: smd_top.sv */
`timescale 1ns/1ps
`include "smd_params.svh"

// Contract
// RULE1: shared pin direction bit 3 set makes open-drain output; clear or reset makes input.
// RULE2: pin direction and pin output function are stored independently.
// RULE3: an output function chosen while pin is input leaves input behaviour alone.
// RULE4: low-register bit 0 selects external off-track input, else internal and pin readable.
// RULE5: shared pin level as input is readable through the selected status bit.
// RULE6: shared output: bit1 clear gives right silence, 01 constant low, 11 constant high.
// RULE7: high-register bits 1..0 choose aux a: four-line, subcode, low, high.
// RULE8: high-register bits 3..2 choose aux b: four-line, de-emphasis, low, high.
// RULE9: motor config field selects pulse density, two-line pwm, four-line pwm or cdv.
// RULE10: drive value comes from buffer fill (plus or minus 8 frames) and disc speed.
// RULE11: pulse density on first output; 50 % no drive, more accelerates, less brakes.
// RULE12: in pulse density the second output is the inverse of the first.
// RULE13: in pulse density outputs change only on the 1 MHz times speed tick.
// RULE14: two-line pwm: acceleration on first output, braking on second.
// RULE15: four-line pwm also uses both aux outputs for a four-input bridge.
// RULE16: cdv: position pwm at 300 Hz on first, recovered clock density on second.
// RULE17: cdv position pwm spans 20 frames, half-full buffer gives 60 % duty.
// RULE18: density modulator is a first-order accumulator whose carry is the stream.
// RULE19: four-line aux outputs carry low-side controls, never overlapping the same half.
module smd_top (
  // ahb-lite slave
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // servo inputs
  input wire logic signed [4:0] fifo_pos,
  input wire logic [1:0] speed_factor,
  input wire logic [9:0] pll_level,
  input wire smd_pkg::smd_core_t core,
  // pins
  input wire smd_pkg::smd_pins_in_t pins_in,
  output smd_pkg::smd_pins_out_t pins_out,
  // to decoder
  output logic off_track
);

  typedef struct packed {
    logic [3:0] shared_dir;
    logic [3:0] vsel_low;
    logic [3:0] vsel_high;
    logic [3:0] motor_cfg;
    logic [3:0] stat_sel;
    logic [9:0] drive;
    logic wr_pend;
    logic [3:0] wr_idx;
    logic [31:0] rdata;
    logic [7:0] pdm_cnt;
    logic pdm_tick;
    smd_pkg::smd_pins_out_t pins;
  } smd_state_t;

  smd_state_t st_reg;
  smd_state_t st_next;

  logic pdm_bit;
  logic cdv_bit;
  logic pwm_acc;
  logic pwm_brk;
  logic pwm_pos;
  logic [9:0] servo_level;
  logic [15:0] acc_duty;
  logic [15:0] brk_duty;
  logic [17:0] pos_duty;
  logic [17:0] pos_per;
  logic [7:0] pdm_div;

  // word index from byte address; aligned words only
  function automatic logic [3:0] reg_index(input logic [31:0] a);
    return a[5:2];
  endfunction

  // scale a 9-bit magnitude to a duty count over a period
  function automatic logic [15:0] scale_duty(input logic [8:0] mag, input logic [15:0] per);
    logic [24:0] prod;
    prod = 25'(mag) * 25'(per);
    return prod[24:9];
  endfunction

  smd_pkg::smd_mode_t mode;
  assign mode = smd_pkg::smd_mode_t'(st_reg.motor_cfg[1:0]); // RULE9

  // cdv leaves the servo level off the motor outputs; the drive register is summed with buffer error in every mode
  always_comb begin
    logic signed [11:0] sum;
    sum = $signed({2'b00, st_reg.drive}) + 12'sd16 * 12'(fifo_pos); // RULE10
    if (sum < 12'sd0) begin
      servo_level = 10'h000;
    end else if (sum > 12'sd1023) begin
      servo_level = 10'h3FF;
    end else begin
      servo_level = sum[9:0];
    end
  end

  // speed factor input n shortens the density tick: 1 MHz * 2^n
  assign pdm_div = 8'(`SMD_PDM_DIV) >> speed_factor;

  // acceleration above mid level, braking below
  assign acc_duty = servo_level[9] ?
    scale_duty({servo_level[8:0]}, 16'(`SMD_PWM_DIV)) : 16'h0000; // RULE14
  assign brk_duty = servo_level[9] ?
    16'h0000 : scale_duty(~servo_level[8:0], 16'(`SMD_PWM_DIV)); // RULE14

  // 300 Hz times speed factor; 18 bits because the slowest period exceeds 16 bits
  assign pos_per = 18'(`SMD_CDV_DIV) >> speed_factor; // RULE16

  // 20-frame window offset so that the buffer centre sits at 12 of 20 frames
  always_comb begin
    logic signed [6:0] fr;
    fr = 7'(fifo_pos) + 7'sd12; // RULE17
    if (fr < 7'sd0) begin
      pos_duty = 18'h00000;
    end else if (fr > 7'sd20) begin
      pos_duty = pos_per;
    end else begin
      pos_duty = 18'((32'(fr) * 32'(pos_per)) / `SMD_CDV_SPAN); // RULE16
    end
  end

  smd_pdm u_pdm (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(st_reg.pdm_tick),
    .level(servo_level),
    .bit_out(pdm_bit)
  ); // RULE18

  smd_pwm u_pwm_acc (
    .hclk(hclk),
    .hresetn(hresetn),
    .period(18'(`SMD_PWM_DIV)),
    .duty({2'b00, acc_duty}),
    .pwm_out(pwm_acc)
  );

  smd_pwm u_pwm_brk (
    .hclk(hclk),
    .hresetn(hresetn),
    .period(18'(`SMD_PWM_DIV)),
    .duty({2'b00, brk_duty}),
    .pwm_out(pwm_brk)
  );

  smd_pwm u_pwm_pos (
    .hclk(hclk),
    .hresetn(hresetn),
    .period(pos_per),
    .duty(pos_duty),
    .pwm_out(pwm_pos)
  );

  // recovered clock level in density form; updated every 40 MHz clock cycle, not at 4.23 MHz
  smd_pdm u_pdm_cdv (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(1'b1),
    .level(pll_level),
    .bit_out(cdv_bit)
  ); // RULE16

  always_comb begin
    logic [3:0] idx;
    logic status_bit;
    st_next = st_reg;
    idx = reg_index(haddr);
    st_next.pdm_tick = 1'b0;
    if (st_reg.pdm_cnt >= pdm_div - 8'h01) begin
      st_next.pdm_cnt = 8'h00;
      st_next.pdm_tick = 1'b1;
    end else begin
      st_next.pdm_cnt = st_reg.pdm_cnt + 8'h01;
    end

    // write data phase
    st_next.wr_pend = 1'b0;
    if (st_reg.wr_pend) begin
      case (st_reg.wr_idx)
        `SMD_IDX_SHARED_DIR: st_next.shared_dir = hwdata[3:0]; // RULE2
        `SMD_IDX_VSEL_LOW: st_next.vsel_low = hwdata[3:0]; // RULE2
        `SMD_IDX_VSEL_HIGH: st_next.vsel_high = hwdata[3:0];
        `SMD_IDX_MOTOR_CFG: st_next.motor_cfg = hwdata[3:0];
        `SMD_IDX_STAT_SEL: st_next.stat_sel = hwdata[3:0];
        `SMD_IDX_DRIVE: st_next.drive = hwdata[9:0];
        default: st_next.wr_pend = 1'b0;
      endcase
    end

    // shared pin level shows only while the pin is an input and selected
    status_bit = 1'b0;
    if (st_reg.stat_sel == 4'h0) begin
      status_bit = st_reg.shared_dir[`SMD_DIR_BIT] ? 1'b0 : pins_in.shared_level; // RULE5
    end else if (st_reg.stat_sel == 4'h1) begin
      status_bit = st_reg.vsel_low[`SMD_VL_EXT_OFFTRACK] ? 1'b0 : pins_in.ext_off_track; // RULE4
    end

    // address phase
    if (hsel && hready && htrans[1]) begin
      st_next.wr_pend = hwrite;
      st_next.wr_idx = idx;
      case (idx)
        `SMD_IDX_SHARED_DIR: st_next.rdata = {28'h0000000, st_reg.shared_dir};
        `SMD_IDX_VSEL_LOW: st_next.rdata = {28'h0000000, st_reg.vsel_low};
        `SMD_IDX_VSEL_HIGH: st_next.rdata = {28'h0000000, st_reg.vsel_high};
        `SMD_IDX_MOTOR_CFG: st_next.rdata = {28'h0000000, st_reg.motor_cfg};
        `SMD_IDX_STAT_SEL: st_next.rdata = {28'h0000000, st_reg.stat_sel};
        `SMD_IDX_DRIVE: st_next.rdata = {22'h000000, st_reg.drive};
        `SMD_IDX_STATUS: st_next.rdata = {20'h00000, servo_level, 1'b0, status_bit};
        default: st_next.rdata = 32'h00000000;
      endcase
    end

    // motor outputs
    case (mode)
      smd_pkg::SMD_MODE_PDM: begin
        st_next.pins.motor_out_first = pdm_bit; // RULE11 RULE13
        st_next.pins.motor_out_second = ~pdm_bit; // RULE12
      end
      smd_pkg::SMD_MODE_PWM2, smd_pkg::SMD_MODE_PWM4: begin
        st_next.pins.motor_out_first = pwm_acc; // RULE14
        st_next.pins.motor_out_second = pwm_brk; // RULE14
      end
      smd_pkg::SMD_MODE_CDV: begin
        st_next.pins.motor_out_first = pwm_pos; // RULE16
        st_next.pins.motor_out_second = cdv_bit; // RULE16
      end
      default: begin
        st_next.pins.motor_out_first = 1'b0;
        st_next.pins.motor_out_second = 1'b0;
      end
    endcase

    // aux a
    case (st_reg.vsel_high[1:0])
      2'b00: begin
        // low side opposite the active high side, only in four-line mode
        st_next.pins.aux_output_pin_a = (mode == smd_pkg::SMD_MODE_PWM4) && !pwm_acc
          && pwm_brk; // RULE15 RULE19
      end
      2'b01: st_next.pins.aux_output_pin_a = core.subcode_qw; // RULE7
      2'b10: st_next.pins.aux_output_pin_a = 1'b0; // RULE7
      default: st_next.pins.aux_output_pin_a = 1'b1; // RULE7
    endcase

    // aux b; 00 is the second four-line control
    case (st_reg.vsel_high[3:2])
      2'b00: begin
        st_next.pins.aux_output_pin_b = (mode == smd_pkg::SMD_MODE_PWM4) && !pwm_brk
          && pwm_acc; // RULE15 RULE19
      end
      2'b01: st_next.pins.aux_output_pin_b = core.deemph_active; // RULE8
      2'b10: st_next.pins.aux_output_pin_b = 1'b0; // RULE8
      default: st_next.pins.aux_output_pin_b = 1'b1; // RULE8
    endcase

    // shared pin: open drain, so only a low level is driven
    if (!st_reg.vsel_low[`SMD_VL_KILL_SEL]) begin
      st_next.pins.shared_out = core.kill_right_n; // RULE6
    end else begin
      st_next.pins.shared_out = st_reg.vsel_low[`SMD_VL_LEVEL]; // RULE6
    end
    // input role ignores the function field entirely
    st_next.pins.shared_oe_n = !(st_reg.shared_dir[`SMD_DIR_BIT]
      && !st_next.pins.shared_out); // RULE1 RULE3
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.pins.shared_oe_n <= 1'b1;
      st_reg.pins.motor_out_second <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign off_track = st_reg.vsel_low[`SMD_VL_EXT_OFFTRACK] ?
    pins_in.ext_off_track : core.int_off_track; // RULE4
  assign pins_out = st_reg.pins;
  assign hrdata = st_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

endmodule

/* File: smd_assertions.sv */
`timescale 1ns/1ps
`include "smd_params.svh"

module smd_checker (
  // bus
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  // servo and pins
  input wire smd_pkg::smd_core_t core,
  input wire smd_pkg::smd_pins_in_t pins_in,
  input wire smd_pkg::smd_pins_out_t pins_out,
  input wire logic off_track
);
  logic ap_wr;
  logic [3:0] ap_idx;
  logic [3:0] dir_reg;
  logic [3:0] vl_reg;
  logic [3:0] vh_reg;
  logic [3:0] cfg_reg;
  logic [1:0] settle;
  logic pdm;
  logic four;
  assign pdm = cfg_reg[1:0] == smd_pkg::SMD_MODE_PDM;
  assign four = cfg_reg[1:0] == smd_pkg::SMD_MODE_PWM4 && vh_reg == 4'h0;

  // shadow copies of the direction, select and config registers; settle counts cycles since the last write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      ap_idx <= 4'h0;
      dir_reg <= 4'h0;
      vl_reg <= 4'h0;
      vh_reg <= 4'h0;
      cfg_reg <= 4'h0;
      settle <= 2'h0;
    end else begin
      ap_wr <= hsel && hready && htrans[1] && hwrite;
      ap_idx <= haddr[5:2];
      settle <= ap_wr ? 2'h0 : (settle == 2'h3 ? settle : settle + 2'h1);
      if (ap_wr && ap_idx == `SMD_IDX_SHARED_DIR) dir_reg <= hwdata[3:0];
      if (ap_wr && ap_idx == `SMD_IDX_VSEL_LOW) vl_reg <= hwdata[3:0];
      if (ap_wr && ap_idx == `SMD_IDX_VSEL_HIGH) vh_reg <= hwdata[3:0];
      if (ap_wr && ap_idx == `SMD_IDX_MOTOR_CFG) cfg_reg <= hwdata[3:0];
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_od_low_only: assert property (!pins_out.shared_oe_n |-> !pins_out.shared_out)
    else $error("shared pin driven high");
  a_dir_input: assert property (!dir_reg[3] && settle != 2'h0 |-> pins_out.shared_oe_n)
    else $error("shared pin driven while input");
  a_shared_level: assert property (dir_reg[3] && vl_reg[1] && settle != 2'h0
    |-> pins_out.shared_oe_n == vl_reg[2]) else $error("shared constant level wrong");
  a_shared_kill: assert property (dir_reg[3] && !vl_reg[1] && settle != 2'h0
    |-> pins_out.shared_oe_n == $past(core.kill_right_n)) else $error("silence output wrong");
  a_off_track_sel: assert property (off_track ==
    (vl_reg[0] ? pins_in.ext_off_track : core.int_off_track)) else $error("off-track source");
  a_aux_a_const: assert property (vh_reg[1] && settle != 2'h0
    |-> pins_out.aux_output_pin_a == vh_reg[0]) else $error("aux a constant wrong");
  a_aux_a_subcode: assert property (vh_reg[1:0] == 2'b01 && settle != 2'h0
    |-> pins_out.aux_output_pin_a == $past(core.subcode_qw)) else $error("aux a subcode");
  a_aux_b_field: assert property (vh_reg[3:2] != 2'b00 && settle != 2'h0
    |-> pins_out.aux_output_pin_b == (vh_reg[3] ? vh_reg[2] : $past(core.deemph_active)))
    else $error("aux b wrong");
  a_pdm_inverse: assert property (pdm && settle != 2'h0
    |-> pins_out.motor_out_second == !pins_out.motor_out_first) else $error("pdm not inverse");
  a_pdm_tick: assert property (pdm && settle == 2'h3 && $changed(pins_out.motor_out_first)
    |=> (!pdm || $stable(pins_out.motor_out_first)) [*4]) else $error("pdm off tick");
  a_bridge_safe: assert property (four && settle != 2'h0
    |-> !(pins_out.motor_out_first && pins_out.aux_output_pin_a)
    && !(pins_out.motor_out_second && pins_out.aux_output_pin_b)) else $error("bridge overlap");
endmodule

bind smd_top smd_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .core(core),
  .pins_in(pins_in), .pins_out(pins_out), .off_track(off_track));

/* File: smd_board_model.sv */
`timescale 1ns/1ps

module smd_board_model (
  // pins from the block
  input wire smd_pkg::smd_pins_out_t pins_out,
  // board sources
  input wire logic ext_pull_low,
  input wire logic ext_off_track,
  // pins to the block
  output wire smd_pkg::smd_pins_in_t pins_in
);
  // pull-up on the shared pin, so a released pin reads high unless the board pulls it
  assign pins_in = {ext_off_track,
    !((!pins_out.shared_oe_n && !pins_out.shared_out) || ext_pull_low)};
endmodule

/* File: tb_top.sv */
`timescale 1ns/1ps
`include "smd_params.svh"

module tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, off_track, ext_low, ext_off;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, speed_factor;
  logic [2:0] hsize;
  logic signed [4:0] fifo_pos;
  logic [9:0] pll_level;
  smd_pkg::smd_core_t core;
  smd_pkg::smd_pins_in_t pins_in;
  smd_pkg::smd_pins_out_t pins_out;
  int error_cnt, checks_done, h1, h2, ha, hb, e;
  logic [9:0] dv [4] = '{10'h200, 10'h300, 10'h100, 10'h200};
  logic signed [4:0] fp [4] = '{5'h00, 5'h00, 5'h00, 5'h08};
  assign hready = hreadyout;

  smd_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .fifo_pos(fifo_pos), .speed_factor(speed_factor),
    .pll_level(pll_level), .core(core), .pins_in(pins_in), .pins_out(pins_out),
    .off_track(off_track));
  smd_board_model i_board (.pins_out(pins_out), .ext_pull_low(ext_low),
    .ext_off_track(ext_off), .pins_in(pins_in));

  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  // never trust a fixed latency: wait for hready, but give up after a bound
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) begin
      error_cnt++;
      complete_run;
    end
  endtask

  task xfer(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {26'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask

  task rchk(input logic [3:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 32'h0);
    chk(rd, exp);
  endtask

  task idle3;
    repeat (3) @(negedge hclk);
  endtask

  task cnt(input int n);
    h1 = 0;
    h2 = 0;
    ha = 0;
    hb = 0;
    repeat (n) begin
      @(negedge hclk);
      h1 += pins_out.motor_out_first;
      h2 += pins_out.motor_out_second;
      ha += pins_out.aux_output_pin_a;
      hb += pins_out.aux_output_pin_b;
    end
  endtask

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    fifo_pos = 5'h00;
    speed_factor = 2'h2;
    pll_level = 10'h200;
    core = 4'hE;
    ext_low = 1'b0;
    ext_off = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(`SMD_IDX_SHARED_DIR, 32'h0);
    chk(pins_out.shared_oe_n, 1'b1);
    chk(32'(hresp), 32'h0);
    rchk(`SMD_IDX_VSEL_LOW, 32'h0);
    rchk(`SMD_IDX_VSEL_HIGH, 32'h0);
    xfer(1'b1, 4'hF, 32'hF);
    rchk(4'hF, 32'h0);
    // function chosen first, pin still an input
    xfer(1'b1, `SMD_IDX_VSEL_LOW, 32'h2);
    xfer(1'b1, `SMD_IDX_STAT_SEL, 32'h0);
    for (int i = 0; i < 2; i++) begin
      @(posedge hclk);
      ext_low <= (i == 0);
      repeat (4) @(posedge hclk);
      xfer(1'b0, `SMD_IDX_STATUS, 32'h0);
      chk(rd[0], i[0]);
      chk(pins_out.shared_oe_n, 1'b1);
    end
    xfer(1'b1, `SMD_IDX_SHARED_DIR, 32'h8);
    idle3;
    chk(pins_out.shared_oe_n, 1'b0);
    rchk(`SMD_IDX_SHARED_DIR, 32'h8);
    xfer(1'b1, `SMD_IDX_VSEL_LOW, 32'h6);
    idle3;
    chk(pins_out.shared_oe_n, 1'b1);
    xfer(1'b1, `SMD_IDX_VSEL_LOW, 32'h0);
    core.kill_right_n <= 1'b0;
    idle3;
    chk(pins_out.shared_oe_n, 1'b0);
    xfer(1'b1, `SMD_IDX_SHARED_DIR, 32'h0);
    core.kill_right_n <= 1'b1;
    xfer(1'b1, `SMD_IDX_STAT_SEL, 32'h1);
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, `SMD_IDX_VSEL_LOW, 32'(i));
      idle3;
      chk(off_track, i[0]);
      xfer(1'b0, `SMD_IDX_STATUS, 32'h0);
      chk(rd[0], !i[0]);
    end
    // subcode and de-emphasis vary so a constant cannot pass for them
    for (int f = 0; f < 16; f++) begin
      xfer(1'b1, `SMD_IDX_VSEL_HIGH, 32'(f));
      core.subcode_qw <= f[3];
      core.deemph_active <= f[1];
      rchk(`SMD_IDX_VSEL_HIGH, 32'(f));
      idle3;
      if (f[1:0] != 2'b00) chk(pins_out.aux_output_pin_a, f[1:0] == 2'b01 ? f[3] : f[0]);
      if (f[3:2] != 2'b00) chk(pins_out.aux_output_pin_b, f[3:2] == 2'b01 ? f[1] : f[2]);
    end
    xfer(1'b1, `SMD_IDX_VSEL_HIGH, 32'h0);
    for (int m = 0; m < 4; m++) begin
      xfer(1'b1, `SMD_IDX_MOTOR_CFG, 32'(m));
      rchk(`SMD_IDX_MOTOR_CFG, 32'(m));
    end
    xfer(1'b1, `SMD_IDX_MOTOR_CFG, 32'h0);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `SMD_IDX_DRIVE, 32'(dv[i]));
      fifo_pos <= fp[i];
      repeat (40) @(negedge hclk);
      cnt(800);
      e = (int'(dv[i]) + 16 * int'(fp[i])) * 800 / 1024;
      chk(32'(h1 >= e - 30 && h1 <= e + 30), 32'h1);
    end
    @(posedge hclk);
    fifo_pos <= 5'h00;
    for (int m = 1; m < 4; m += 2) begin
      xfer(1'b1, `SMD_IDX_MOTOR_CFG, 32'(m));
      xfer(1'b1, `SMD_IDX_DRIVE, 32'h300);
      cnt(1814);
      cnt(1814);
      chk(32'(h1 > 0 && h2 == 0), 32'h1);
      if (m == 3) chk(32'(hb > 0 && ha == 0), 32'h1);
      xfer(1'b1, `SMD_IDX_DRIVE, 32'h100);
      cnt(1814);
      cnt(1814);
      chk(32'(h1 == 0 && h2 > 0), 32'h1);
      if (m == 3) chk(32'(ha > 0 && hb == 0), 32'h1);
    end
    xfer(1'b1, `SMD_IDX_MOTOR_CFG, 32'h2);
    speed_factor <= 2'h3;
    idle3;
    cnt(400);
    chk(32'(h2 >= 180 && h2 <= 220), 32'h1);
    // one whole position period at speed factor 8; nominal buffer gives 60 %
    e = `SMD_CDV_DIV / 8 * 60 / 100;
    cnt(`SMD_CDV_DIV / 8);
    chk(32'(h1 >= e - 100 && h1 <= e + 100), 32'h1);
    complete_run;
  end
endmodule
